// File: common/sacs_params.svh
`ifndef SACS_PARAMS_SVH
`define SACS_PARAMS_SVH
// conversion timing, in bus clock cycles
`define SACS_CONV_CYCLES    6'd32
`define SACS_SAMPLE_CYCLES  6'd12
`define SACS_COMPARE_CYCLES 6'd20
`define SACS_XFER_CYCLES    2'd2
// result width and dac code width
`define SACS_RES_W          8
`define SACS_RES_MSB        3'd7
// analog pins sit on port bits 3..6
`define SACS_AN_BASE        3'd3
`define SACS_PORT_W         8
`define SACS_ZERO8          8'h00
`define SACS_ONE8           8'h01
`endif

// File: common/sacs_pkg.sv
`default_nettype none
package sacs_pkg;
  `include "sacs_params.svh"

  typedef enum {SACS_IDLE, SACS_SAMPLE, SACS_COMPARE, SACS_XFER} sacs_phase_t;

  // converter control as seen by the sequencer
  typedef struct packed {
    logic       enable;
    logic       start;
    logic [1:0] channel;   // channel_select_high, channel_select_low
  } sacs_ctrl_t;

  // analog front end drive
  typedef struct packed {
    logic [3:0] chan_onehot;
    logic       sample;
    logic       compare;
    logic [7:0] dac_code;
  } sacs_afe_t;
endpackage : sacs_pkg
`default_nettype wire

// File: rtl/sacs_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two flop synchroniser for pin level inputs
module sacs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;
  // first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sacs_sync
`default_nettype wire

// File: rtl/sacs_sequencer.sv
// Operation
// - exactly one of four channels routed to sampling at a time
// - a conversion takes 32 cycles from start to the conversion done flag
// - first 12 cycles hold sampling active
// - last 20 cycles run the comparison phase
// - code decided one bit per step, msb first
// - conversion done flag set at the end of a conversion
// - result moved to the data register within 2 cycles of the flag
// - two channel select bits choose the analog pin
// - while enabled, port read of the selected analog pin returns zero
// - reset switches the converter off and frees the shared pins
`timescale 1ns/1ps
`default_nettype none
`include "sacs_params.svh"
module sacs_sequencer (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire sacs_pkg::sacs_ctrl_t   ctrl,
  input  wire logic                   done_clear,
  input  wire logic                   comp_in,
  input  wire logic [7:0]             port_pins,
  output var  sacs_pkg::sacs_afe_t    afe,
  output var  logic                   conversion_done_flag,
  output var  logic [7:0]             result_data,
  output var  logic [7:0]             port_read,
  output var  logic                   busy
);
  import sacs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // port pins are asynchronous to clk
  logic [7:0] pins_s;
  sacs_sync #(.W(`SACS_PORT_W)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (port_pins),
    .q    (pins_s)
  );
  // the comparator is latched on clk by the analog front end, so it is
  // same-domain; two sync flops would eat the two cycles each bit gets
  logic comp_s;
  assign comp_s = comp_in;

  // one hot channel decode, used for mux drive and port masking
  function automatic logic [3:0] chan_dec(input logic [1:0] ch);
    chan_dec = 4'h1 << ch;
  endfunction : chan_dec

  // analog pin of one channel on the shared port
  function automatic logic [7:0] port_mask(input logic [1:0] ch);
    port_mask = {4'h0, chan_dec(ch)} << `SACS_AN_BASE;
  endfunction : port_mask

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    sacs_phase_t phase;
    logic [5:0]  cyc;
    logic [1:0]  xcnt;
    logic [2:0]  bitpos;
    logic [7:0]  sar;
    logic [1:0]  chan;
    sacs_afe_t   afe;
    logic        done;
    logic [7:0]  result;
    logic [7:0]  port_rd;
    logic        busy;
    logic [5:0]  chk_samp;  // assertion helpers: phase run lengths
    logic [5:0]  chk_comp;
    logic [5:0]  chk_age;   // cycles since sampling began
  } sacs_state_t;

  sacs_state_t st, next_st;

  // sequencing of sample, compare and transfer
  always_comb begin
    logic [3:0] onehot;
    logic [7:0] mask;
    onehot  = 4'h0;
    mask    = `SACS_ZERO8;
    next_st = st;
    next_st.cyc = st.cyc + 6'd1;
    case (st.phase)
      SACS_IDLE: begin
        next_st.cyc = 6'd0;
        if (ctrl.enable && ctrl.start) begin
          next_st.phase  = SACS_SAMPLE;
          next_st.chan   = ctrl.channel;
          next_st.cyc    = 6'd1;
          next_st.sar    = `SACS_ZERO8;
          next_st.bitpos = `SACS_RES_MSB;
        end
      end
      SACS_SAMPLE: begin
        if (st.cyc == `SACS_SAMPLE_CYCLES) begin
          next_st.phase = SACS_COMPARE;
          next_st.sar   = `SACS_ONE8 << `SACS_RES_MSB;
        end
      end
      SACS_COMPARE: begin
        // trial bit kept when dac does not exceed sample; the
        // comparator answers a new code two edges later, so bits 7..1 are
        // decided on even cycles and bit 0 just before the phase ends
        if (!st.cyc[0] && st.bitpos != 3'd0 || st.cyc == `SACS_CONV_CYCLES - 6'd1) begin
          if (comp_s == 1'b0)
            next_st.sar[st.bitpos] = 1'b0;
          if (st.bitpos != 3'd0) begin
            next_st.bitpos = st.bitpos - 3'd1;
            next_st.sar[st.bitpos - 3'd1] = 1'b1;
          end
        end
        if (st.cyc == `SACS_CONV_CYCLES) begin
          next_st.phase = SACS_XFER;
          next_st.done  = 1'b1;
          next_st.xcnt  = 2'd1;
        end
      end
      SACS_XFER: begin
        next_st.xcnt = st.xcnt + 2'd1;
        if (st.xcnt == `SACS_XFER_CYCLES) begin
          next_st.result = st.sar;
          next_st.phase  = SACS_IDLE;
        end
      end
      default: next_st.phase = SACS_IDLE;
    endcase
    // software clear loses to a fresh completion
    if (done_clear && !(st.phase == SACS_COMPARE && st.cyc == `SACS_CONV_CYCLES))
      next_st.done = 1'b0;
    if (!ctrl.enable) begin
      next_st.phase = SACS_IDLE;
      next_st.cyc   = 6'd0;
    end
    // analog front end drive, one channel only while converting
    if (next_st.phase != SACS_IDLE)
      onehot = chan_dec(next_st.chan);
    next_st.afe.chan_onehot = onehot;
    next_st.afe.sample      = (next_st.phase == SACS_SAMPLE);
    next_st.afe.compare     = (next_st.phase == SACS_COMPARE);
    next_st.afe.dac_code    = next_st.sar;
    // shared port read: selected analog bit reads zero while enabled
    if (ctrl.enable)
      mask = port_mask(ctrl.channel);
    next_st.port_rd = pins_s & ~mask;
    next_st.busy    = (next_st.phase != SACS_IDLE);
    // assertion helpers count from the registered drive, not from cyc,
    // so a wrong phase counter cannot hide behind itself
    next_st.chk_samp = st.afe.sample ? st.chk_samp + 6'd1 : 6'd0;
    next_st.chk_comp = st.afe.compare ? st.chk_comp + 6'd1 : 6'd0;
    next_st.chk_age  = (st.afe.sample || st.afe.compare) ? st.chk_age + 6'd1 : 6'd0;
  end

  // reset leaves converter idle and port as plain digital
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      st <= '{phase: SACS_IDLE, default: '0};
    else
      st <= next_st;
  end

  assign afe                  = st.afe;
  assign conversion_done_flag = st.done;
  assign result_data          = st.result;
  assign port_read            = st.port_rd;
  assign busy                 = st.busy;

  ////////////////////////////////////////////////////////////////////////
  a_sample_len: assert property (@(posedge clk) disable iff (!rstn)
    $rose(afe.compare) |-> st.chk_samp == `SACS_SAMPLE_CYCLES)
    else $error("sampling phase not 12 cycles");
  a_compare_len: assert property (@(posedge clk) disable iff (!rstn)
    $fell(afe.compare) && busy |-> st.chk_comp == `SACS_COMPARE_CYCLES)
    else $error("compare phase not 20 cycles");
  a_total_len: assert property (@(posedge clk) disable iff (!rstn)
    $fell(afe.compare) && busy |-> st.chk_age == `SACS_CONV_CYCLES)
    else $error("conversion not 32 cycles");
  a_done_time: assert property (@(posedge clk) disable iff (!rstn)
    $rose(conversion_done_flag) |-> st.chk_age == `SACS_CONV_CYCLES)
    else $error("done not after 32 cycles");
  a_done_set: assert property (@(posedge clk) disable iff (!rstn)
    $fell(afe.compare) && ctrl.enable |-> conversion_done_flag)
    else $error("done flag missing at end");
  a_result_xfer: assert property (@(posedge clk) disable iff (!rstn)
    $rose(conversion_done_flag) && ctrl.enable |-> ##[1:2] (result_data == $past(afe.dac_code)))
    else $error("result not moved in 2 cycles");
  a_one_chan: assert property (@(posedge clk) disable iff (!rstn)
    busy |-> $onehot(afe.chan_onehot))
    else $error("not exactly one channel");
  a_msb_first: assert property (@(posedge clk) disable iff (!rstn)
    $rose(afe.compare) |-> afe.dac_code == 8'h80)
    else $error("first trial not msb");
  a_port_mask: assert property (@(posedge clk) disable iff (!rstn)
    ctrl.enable && $stable(ctrl.enable) && $stable(ctrl.channel)
      |=> (port_read & port_mask($past(ctrl.channel))) == `SACS_ZERO8)
    else $error("selected pin not read as zero");
  a_reset_off: assert property (@(posedge clk)
    $rose(rstn) |-> !busy && afe.chan_onehot == 4'h0)
    else $error("converter on after reset");
endmodule : sacs_sequencer
`default_nettype wire

// File: tb/sacs_comp_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: input mux and comparator facing the sequencer
module sacs_comp_model (
  input  wire logic                clk,
  input  wire sacs_pkg::sacs_afe_t afe,
  input  wire logic [31:0]         levels,
  output var  logic                comp
);
  import sacs_pkg::*;
  logic [7:0] lvl;
  initial comp = 1'b0;
  // held sample follows the one hot select
  always_comb begin
    lvl = 8'h00;
    for (int i = 0; i < 4; i++) if (afe.chan_onehot[i]) lvl = levels[i*8 +: 8];
  end
  // toggles outside compare so a stale level is never trusted
  always @(posedge clk) comp <= afe.compare ? (lvl >= afe.dac_code) : ~comp;
endmodule : sacs_comp_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sacs_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        done_clear = 1'b0;
  logic        comp_in;
  sacs_ctrl_t  ctrl = '0;
  logic [7:0]  port_pins = 8'h00;
  logic [31:0] levels = 32'h0;
  logic [7:0]  result_data;
  logic [7:0]  port_read;
  sacs_afe_t   afe;
  logic        conversion_done_flag;
  logic        busy;
  int          err_count = 0;
  int          checks = 0;
  int          seed = 82;
  int          exp_q[$];
  sacs_sequencer dut (.clk(clk), .rstn(rstn), .ctrl(ctrl), .done_clear(done_clear), .comp_in(comp_in),
    .port_pins(port_pins), .afe(afe), .conversion_done_flag(conversion_done_flag),
    .result_data(result_data), .port_read(port_read), .busy(busy));
  sacs_comp_model far (.clk(clk), .afe(afe), .levels(levels), .comp(comp_in));
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  // bench model: msb first successive approximation on integers
  function automatic int sar_ref(input int level);
    int code;
    code = 0;
    for (int b = 7; b >= 0; b--) begin
      code = code | (1 << b);
      if (code > level) code = code & ~(1 << b);
    end
    return code;
  endfunction : sar_ref
  // one conversion; start stays high into busy to show it is ignored
  task automatic conv(input logic [1:0] ch);
    int n_s, n_c, k_d, k_r;
    logic [7:0] lvl, pins, code1;
    logic [3:0] oh;
    n_s = 0;
    n_c = 0;
    k_d = 0;
    k_r = 0;
    lvl = 8'($random(seed));
    pins = 8'($random(seed));
    exp_q.push_back(sar_ref(lvl));
    @(posedge clk);
    levels[ch*8 +: 8] <= lvl;
    port_pins <= pins;
    ctrl <= '{enable: 1'b1, start: 1'b1, channel: ch};
    // k counts edges from the one that takes the start
    for (int k = 0; k <= 40; k++) begin
      @(posedge clk);
      if (k == 20) ctrl.start <= 1'b0;
      @(negedge clk);
      if (k == 1) oh = afe.chan_onehot;
      if (k == 12) code1 = afe.dac_code;
      if (k == 30 && afe.chan_onehot !== oh) oh = 4'hf;
      if (afe.sample) n_s++;
      if (afe.compare) n_c++;
      if (conversion_done_flag && k_d == 0) k_d = k;
      if (k > 1 && !busy && k_r == 0) k_r = k;
    end
    check("onehot", oh, 4'b1 << ch);
    check("sample cycles", n_s, 12);
    check("compare cycles", n_c, 20);
    check("first trial", code1, 8'h80);
    check("done cycle", k_d, 32);
    check("transfer delay", k_r - k_d, 2);
    check("result", result_data, exp_q.pop_front());
    check("port read", port_read, pins & ~(8'h01 << (3 + ch)));
    @(posedge clk) done_clear <= 1'b1;
    @(posedge clk) done_clear <= 1'b0;
    @(negedge clk);
    check("done cleared", conversion_done_flag, 0);
  endtask : conv
  // main sequence: every channel, abort by disable, reset mid run
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int c = 0; c < 4; c++) conv(2'(c));
    $display("test channels done");
    @(posedge clk) ctrl <= '{1'b1, 1'b1, 2'd1};
    repeat (6) @(posedge clk);
    ctrl <= '0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("abort busy", busy, 0);
    check("abort afe", afe, 0);
    $display("test abort done");
    @(posedge clk) ctrl <= '{1'b1, 1'b1, 2'd2};
    repeat (8) @(posedge clk);
    rstn <= 1'b0;
    ctrl <= '0;
    @(negedge clk);
    check("reset busy", busy, 0);
    check("reset afe", afe, 0);
    check("reset port", port_read, 0);
    @(posedge clk) rstn <= 1'b1;
    conv(2'd3);
    $display("test reset done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
